/* logic/rtc_defs.svh */
// Purpose: Constants shared by both ends of the serial clock link.
// Assumes: Byte-wide device registers, 32-bit APB host registers.
// Notes: Device offsets are register indices on the serial link; host offsets are APB byte addresses.
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

`define RTC_A_SEC 4'h0
`define RTC_A_MIN 4'h1
`define RTC_A_HOUR 4'h2
`define RTC_A_WDAY 4'h3
`define RTC_A_MDAY 4'h4
`define RTC_A_MON 4'h5
`define RTC_A_YEAR 4'h6
`define RTC_A_ADJ 4'h7
`define RTC_A_CTRL1 4'he
`define RTC_A_CTRL2 4'hf

`define RTC_M_SEC 8'h7f
`define RTC_M_MIN 8'h7f
`define RTC_M_HOUR 8'h3f
`define RTC_M_WDAY 8'h07
`define RTC_M_MDAY 8'h3f
`define RTC_M_MON 8'h9f
`define RTC_M_YEAR 8'hff
`define RTC_M_ADJ 8'h7f
`define RTC_M_CTRL2W 8'ha8

`define RTC_B_WEEKLY_ALARM_ENABLE 7
`define RTC_B_DAILY_ALARM_ENABLE 6
`define RTC_B_H24 5
`define RTC_B_SUBCLK_OUT_DISABLE_B 4
`define RTC_B_CENT 7
`define RTC_B_OSC_HALT_FLAG 4
`define RTC_B_SUBCLK_OUT_DISABLE_A 3
`define RTC_B_PERIODIC_IRQ_FLAG 2
`define RTC_B_WEEKLY_ALARM_FLAG 1
`define RTC_B_DAILY_ALARM_FLAG 0

`define RTC_R_CTRL2 8'h10
`define RTC_R_TIME 8'h00
`define RTC_R_DAY 8'h01

`define RTC_CLK_NS 50
`define RTC_ALARM_DLY_NS 61000
`define RTC_ALARM_DLY_CYC ((`RTC_ALARM_DLY_NS + `RTC_CLK_NS - 1) / `RTC_CLK_NS)

`define RTC_H_CMD 12'h000
`define RTC_H_STAT 12'h004
`define RTC_H_CTRL 12'h008
`define RTC_H_RD_BIT 8

`endif

/* logic/rtc_pkg.sv */
// Purpose: Types for both ends of the serial clock link.
// Assumes: Each module keeps all of its state in one struct.
// Notes: State codes are one-hot.
package rtc_pkg;

  typedef enum logic [3:0] {
    RTC_H_IDLE = 4'h1,
    RTC_H_SHIFT = 4'h2,
    RTC_H_HOLD = 4'h4,
    RTC_H_GAP = 4'h8
  } rtc_hstate_t;

  typedef struct packed {
    logic [1:0] ce_s;
    logic [1:0] sclk_s;
    logic [1:0] sio_s;
    logic [1:0] halt_s;
    logic [1:0] cpin_s;
    logic sclk_d;
    logic [4:0] bit_cnt;
    logic [7:0] sh_in;
    logic rd;
    logic [7:0] sh_out;
    logic drive;
    logic [15:0] xdiv;
    logic subclk;
    logic irq;
    logic [14:0] presc;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] mday;
    logic [7:0] mon;
    logic [7:0] year;
    logic [7:0] adj;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic wpend;
    logic dpend;
    logic [10:0] wdly;
    logic [10:0] ddly;
  } rtc_dev_st_t;

  typedef struct packed {
    rtc_hstate_t state;
    logic [7:0] div;
    logic sclk;
    logic ce;
    logic [15:0] sh;
    logic oe;
    logic [3:0] cnt;
    logic rd;
    logic [7:0] rdata;
    logic [1:0] sio_s;
    logic [1:0] irq_s;
    logic cpin;
    logic [31:0] prdata;
  } rtc_host_st_t;

endpackage : rtc_pkg

/* logic/rtc_link_if.sv */
// Purpose: Three-wire link plus interrupt and sub-clock pins.
// Assumes: Data line and interrupt line have pull-ups.
// Notes: Wire levels are resolved here from the enables.
`timescale 1ns/1ns
interface rtc_link_if;
  logic ce;
  logic sclk;
  logic host_sio_out;
  logic host_sio_oe;
  logic dev_sio_out;
  logic dev_sio_oe;
  logic sio;
  logic dev_irq_out;
  logic dev_irq_oe;
  logic irq_out_pin;
  logic subclk_out_pin;
  logic subclk_control_pin;

  assign sio = host_sio_oe ? host_sio_out : (dev_sio_oe ? dev_sio_out : 1'b1);
  assign irq_out_pin = dev_irq_oe ? dev_irq_out : 1'b1;

  modport dev (input ce, input sclk, input sio, input subclk_control_pin,
    output dev_sio_out, output dev_sio_oe, output dev_irq_out, output dev_irq_oe,
    output subclk_out_pin);
  modport host (output ce, output sclk, output host_sio_out, output host_sio_oe,
    output subclk_control_pin, input sio, input irq_out_pin, input subclk_out_pin);
endinterface : rtc_link_if

/* logic/rtc_dev.sv */
// Purpose: Timekeeping core with halt flag, sub-clock and interrupt flags.
// Assumes: Crystal ticks made from pclk by XTAL_DIV; alarm match pulses from outside.
// Notes: Frame is address byte (addr[7:4], read bit 3) then one data byte.
//
// Chosen here: the crystal stand-in divided down from pclk.
`timescale 1ns/1ns
`include "rtc_defs.svh"
module rtc_dev
  import rtc_pkg::*;
#(
  parameter int XTAL_DIV = 610
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic osc_halt,
  input wire logic weekly_alarm_match,
  input wire logic daily_alarm_match,
  rtc_link_if.dev bus
);

  localparam logic [15:0] XDIV_LAST = 16'(XTAL_DIV - 1);
  localparam logic [15:0] XDIV_HALF = 16'(XTAL_DIV / 2);
  localparam logic [10:0] ALM_LAST = 11'(`RTC_ALARM_DLY_CYC - 1);

  if (XTAL_DIV < 2 || XTAL_DIV > 65535) begin : g_bad_div
    $error("XTAL_DIV out of range");
  end

  rtc_dev_st_t s;
  rtc_dev_st_t n;

  // BCD step with wrap: {carry, next}
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
    if (v == hi) begin
      bcd_step = {1'b1, lo};
    end else if (v[3:0] == 4'h9) begin
      bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_step = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_step

  function automatic logic [8:0] hour_step(input logic [7:0] h, input logic h24);
    if (h24) begin
      hour_step = bcd_step(h, 8'h00, 8'h23);
    end else if (h == 8'h31) begin
      hour_step = {1'b1, 8'h12};
    end else if (h == 8'h11) begin
      hour_step = {1'b0, 8'h32};
    end else if (h[4:0] == 5'h12) begin
      hour_step = {1'b0, h[7:5], 5'h01};
    end else begin
      hour_step = {1'b0, h[7:5], 5'(bcd_step({3'h0, h[4:0]}, 8'h00, 8'hff))};
    end
  endfunction : hour_step

  function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
                  (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (m == 8'h02) begin
      last_day = leap ? 8'h29 : 8'h28;
    end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
      last_day = 8'h30;
    end else begin
      last_day = 8'h31;
    end
  endfunction : last_day

  function automatic logic periodic_low(input rtc_dev_st_t st);
    unique case (st.ctrl1[2:0])
      3'h0: periodic_low = 1'b0;
      3'h1: periodic_low = 1'b1;
      3'h2: periodic_low = ~st.presc[13];
      3'h3: periodic_low = ~st.presc[14];
      default: periodic_low = st.ctrl2[`RTC_B_PERIODIC_IRQ_FLAG];
    endcase
  endfunction : periodic_low

  function automatic logic [7:0] reg_read(input rtc_dev_st_t st, input logic [3:0] a);
    logic [7:0] c2;
    c2 = st.ctrl2 & 8'hbf;
    c2[`RTC_B_PERIODIC_IRQ_FLAG] = periodic_low(st);
    c2[`RTC_B_WEEKLY_ALARM_FLAG] = st.ctrl2[`RTC_B_WEEKLY_ALARM_FLAG] & st.ctrl1[`RTC_B_WEEKLY_ALARM_ENABLE];
    c2[`RTC_B_DAILY_ALARM_FLAG] = st.ctrl2[`RTC_B_DAILY_ALARM_FLAG] & st.ctrl1[`RTC_B_DAILY_ALARM_ENABLE];
    unique case (a)
      `RTC_A_SEC: reg_read = st.sec & `RTC_M_SEC;
      `RTC_A_MIN: reg_read = st.min & `RTC_M_MIN;
      `RTC_A_HOUR: reg_read = st.hour & `RTC_M_HOUR;
      `RTC_A_WDAY: reg_read = st.wday & `RTC_M_WDAY;
      `RTC_A_MDAY: reg_read = st.mday & `RTC_M_MDAY;
      `RTC_A_MON: reg_read = st.mon & `RTC_M_MON;
      `RTC_A_YEAR: reg_read = st.year;
      `RTC_A_ADJ: reg_read = st.adj & `RTC_M_ADJ;
      `RTC_A_CTRL1: reg_read = st.ctrl1;
      `RTC_A_CTRL2: reg_read = c2;
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  logic rise;
  logic fall;
  logic tick;
  logic wr_en;
  logic [7:0] wd;
  logic [8:0] c_sec;
  logic [8:0] c_min;
  logic [8:0] c_hour;
  logic [8:0] c_mday;
  logic [8:0] c_mon;
  logic [8:0] c_year;
  logic sec_ev;
  logic [3:0] wa;

  always_comb begin
    n = s;
    n.ce_s = {s.ce_s[0], bus.ce};
    n.sclk_s = {s.sclk_s[0], bus.sclk};
    n.sio_s = {s.sio_s[0], bus.sio};
    n.halt_s = {s.halt_s[0], osc_halt};
    n.cpin_s = {s.cpin_s[0], bus.subclk_control_pin};
    n.sclk_d = s.sclk_s[1];
    rise = s.sclk_s[1] & ~s.sclk_d;
    fall = ~s.sclk_s[1] & s.sclk_d;
    wr_en = 1'b0;
    wd = {s.sh_in[6:0], s.sio_s[1]};
    wa = s.sh_out[3:0];
    tick = 1'b0;
    sec_ev = 1'b0;
    c_sec = 9'h0;
    c_min = 9'h0;
    c_hour = 9'h0;
    c_mday = 9'h0;
    c_mon = 9'h0;
    c_year = 9'h0;

    // Crystal stand-in; stops while the oscillator is halted
    if (!s.halt_s[1]) begin
      if (s.xdiv == XDIV_LAST) begin
        n.xdiv = 16'h0000;
        tick = 1'b1;
      end else begin
        n.xdiv = s.xdiv + 16'h0001;
      end
    end
    n.subclk = s.cpin_s[1] & ~(s.ctrl2[`RTC_B_SUBCLK_OUT_DISABLE_A] & s.ctrl1[`RTC_B_SUBCLK_OUT_DISABLE_B]) &
               ~s.halt_s[1] & (s.xdiv < XDIV_HALF);

    // Serial frame; register index kept in a spare field until data arrives
    if (!s.ce_s[1]) begin
      n.bit_cnt = 5'h00;
      n.drive = 1'b0;
    end else begin
      if (rise && s.bit_cnt != 5'h10) begin
        n.sh_in = wd;
        n.bit_cnt = s.bit_cnt + 5'h01;
        if (s.bit_cnt == 5'h07) begin
          n.rd = s.sh_in[2];
          n.sh_out = s.sh_in[2] ? reg_read(s, s.sh_in[6:3]) : {4'h0, s.sh_in[6:3]};
        end
        if (s.bit_cnt == 5'h0f && !s.rd) begin
          wr_en = 1'b1;
        end
      end
      if (fall && s.rd && s.bit_cnt >= 5'h08) begin
        n.drive = 1'b1;
        if (s.bit_cnt >= 5'h09) begin
          n.sh_out = {s.sh_out[6:0], 1'b0};
        end
      end
    end

    // Divider chain and calendar
    if (tick) begin
      n.presc = s.presc + 15'h0001;
      if (s.presc == 15'h7fff) begin
        sec_ev = 1'b1;
        c_sec = bcd_step(s.sec, 8'h00, 8'h59);
        n.sec = c_sec[7:0];
        if (c_sec[8]) begin
          c_min = bcd_step(s.min, 8'h00, 8'h59);
          n.min = c_min[7:0];
        end
        if (c_min[8]) begin
          c_hour = hour_step(s.hour, s.ctrl1[`RTC_B_H24]);
          n.hour = c_hour[7:0];
        end
        if (c_hour[8]) begin
          n.wday = (s.wday[2:0] >= 3'h6) ? 8'h00 : s.wday + 8'h01;
          c_mday = bcd_step(s.mday, 8'h01, last_day(s.mon, s.year));
          n.mday = c_mday[7:0];
        end
        if (c_mday[8]) begin
          c_mon = bcd_step({1'b0, s.mon[6:0]}, 8'h01, 8'h12);
          n.mon = {s.mon[`RTC_B_CENT], c_mon[6:0]};
        end
        if (c_mon[8]) begin
          c_year = bcd_step(s.year, 8'h00, 8'h99);
          n.year = c_year[7:0];
        end
        if (c_year[8]) begin
          n.mon[`RTC_B_CENT] = ~s.mon[`RTC_B_CENT];
        end
      end
    end

    // Host writes; a write to a counter wins over its own carry
    if (wr_en) begin
      unique case (wa)
        `RTC_A_SEC: begin
          n.sec = wd & `RTC_M_SEC;
          n.presc = 15'h0000;
        end
        `RTC_A_MIN: n.min = wd & `RTC_M_MIN;
        `RTC_A_HOUR: n.hour = wd & `RTC_M_HOUR;
        `RTC_A_WDAY: n.wday = wd & `RTC_M_WDAY;
        `RTC_A_MDAY: n.mday = wd & `RTC_M_MDAY;
        `RTC_A_MON: n.mon = wd & `RTC_M_MON;
        `RTC_A_YEAR: n.year = wd;
        `RTC_A_ADJ: n.adj = wd & `RTC_M_ADJ;
        `RTC_A_CTRL1: n.ctrl1 = wd;
        `RTC_A_CTRL2: begin
          n.ctrl2 = (wd & `RTC_M_CTRL2W) | (s.ctrl2 & wd & 8'h17);
        end
        default: n.ctrl2 = n.ctrl2;
      endcase
    end

    // Level-mode periodic events; set wins over a clearing write
    if (s.ctrl1[2] && sec_ev) begin
      unique case (s.ctrl1[1:0])
        2'h0: n.ctrl2[`RTC_B_PERIODIC_IRQ_FLAG] = 1'b1;
        2'h1: n.ctrl2[`RTC_B_PERIODIC_IRQ_FLAG] = n.ctrl2[`RTC_B_PERIODIC_IRQ_FLAG] | c_sec[8];
        2'h2: n.ctrl2[`RTC_B_PERIODIC_IRQ_FLAG] = n.ctrl2[`RTC_B_PERIODIC_IRQ_FLAG] | c_min[8];
        2'h3: n.ctrl2[`RTC_B_PERIODIC_IRQ_FLAG] = n.ctrl2[`RTC_B_PERIODIC_IRQ_FLAG] | c_mday[8];
      endcase
    end

    // Alarm flags rise a fixed delay after the match
    if (weekly_alarm_match) begin
      n.wpend = 1'b1;
      n.wdly = 11'h000;
    end else if (s.wpend) begin
      n.wdly = s.wdly + 11'h001;
      if (s.wdly == ALM_LAST) begin
        n.wpend = 1'b0;
        n.ctrl2[`RTC_B_WEEKLY_ALARM_FLAG] = 1'b1;
      end
    end
    if (daily_alarm_match) begin
      n.dpend = 1'b1;
      n.ddly = 11'h000;
    end else if (s.dpend) begin
      n.ddly = s.ddly + 11'h001;
      if (s.ddly == ALM_LAST) begin
        n.dpend = 1'b0;
        n.ctrl2[`RTC_B_DAILY_ALARM_FLAG] = 1'b1;
      end
    end

    // Halt sensing, only outside a serial access
    if (s.halt_s[1] && !s.ce_s[1] && !s.ctrl2[`RTC_B_OSC_HALT_FLAG]) begin
      n.ctrl2 = `RTC_R_CTRL2;
      n.ctrl1 = 8'h00;
      n.adj = 8'h00;
      n.wpend = 1'b0;
      n.dpend = 1'b0;
    end

    n.irq = periodic_low(s) | (s.ctrl2[`RTC_B_WEEKLY_ALARM_FLAG] & s.ctrl1[`RTC_B_WEEKLY_ALARM_ENABLE]) |
            (s.ctrl2[`RTC_B_DAILY_ALARM_FLAG] & s.ctrl1[`RTC_B_DAILY_ALARM_ENABLE]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.ctrl2 <= `RTC_R_CTRL2;
      s.mday <= `RTC_R_DAY;
      s.mon <= `RTC_R_DAY;
    end else begin
      s <= n;
    end
  end

  assign bus.dev_sio_out = s.sh_out[7];
  assign bus.dev_sio_oe = s.drive;
  assign bus.dev_irq_out = 1'b0;
  assign bus.dev_irq_oe = s.irq;
  assign bus.subclk_out_pin = s.subclk;

endmodule : rtc_dev

/* logic/rtc_host.sv */
// Purpose: APB-controlled master of the three-wire clock link.
// Assumes: One register per frame; the device answers after its sync delay.
// Notes: Serial clock made here from pclk; SCLK_HALF cycles per half period.
`timescale 1ns/1ns
`include "rtc_defs.svh"
module rtc_host
  import rtc_pkg::*;
#(
  parameter int SCLK_HALF = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  rtc_link_if.host bus
);

  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);

  if (SCLK_HALF < 6 || SCLK_HALF > 255) begin : g_bad_half
    $error("SCLK_HALF out of range");
  end

  rtc_host_st_t s;
  rtc_host_st_t n;
  logic mapped;
  logic half_done;

  always_comb begin
    n = s;
    n.sio_s = {s.sio_s[0], bus.sio};
    n.irq_s = {s.irq_s[0], bus.irq_out_pin};
    mapped = (paddr == `RTC_H_CMD) || (paddr == `RTC_H_STAT) || (paddr == `RTC_H_CTRL);
    half_done = (s.div == HALF_LAST);
    n.div = half_done ? 8'h00 : s.div + 8'h01;

    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `RTC_H_STAT: n.prdata = {16'h0000, s.rdata, 6'h00, ~s.irq_s[1],
                                 s.state != RTC_H_IDLE};
        `RTC_H_CTRL: n.prdata = {31'h0, s.cpin};
        default: n.prdata = 32'h0000_0000;
      endcase
    end

    if (psel && penable && pwrite && paddr == `RTC_H_CTRL) begin
      n.cpin = pwdata[0];
    end

    unique case (s.state)
      RTC_H_IDLE: begin
        n.div = 8'h00;
        if (psel && penable && pwrite && paddr == `RTC_H_CMD) begin
          n.state = RTC_H_SHIFT;
          n.ce = 1'b1;
          n.rd = pwdata[`RTC_H_RD_BIT];
          n.sh = {pwdata[3:0], pwdata[`RTC_H_RD_BIT], 3'h0, pwdata[23:16]};
          n.oe = 1'b1;
          n.cnt = 4'h0;
        end
      end
      RTC_H_SHIFT: begin
        if (half_done) begin
          n.sclk = ~s.sclk;
          if (s.sclk) begin
            if (s.rd && s.cnt >= 4'h8) begin
              n.rdata = {s.rdata[6:0], s.sio_s[1]};
            end
            n.sh = {s.sh[14:0], 1'b0};
            n.cnt = s.cnt + 4'h1;
            if (s.rd && s.cnt == 4'h7) begin
              n.oe = 1'b0;
            end
            if (s.cnt == 4'hf) begin
              n.state = RTC_H_HOLD;
              n.oe = 1'b0;
            end
          end
        end
      end
      RTC_H_HOLD: begin
        if (half_done) begin
          n.ce = 1'b0;
          n.state = RTC_H_GAP;
        end
      end
      RTC_H_GAP: begin
        if (half_done) begin
          n.state = RTC_H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.state <= RTC_H_IDLE;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign bus.ce = s.ce;
  assign bus.sclk = s.sclk;
  assign bus.host_sio_out = s.sh[15];
  assign bus.host_sio_oe = s.oe;
  assign bus.subclk_control_pin = s.cpin;

endmodule : rtc_host

/* tb/rtc_link_checker.sv */
// Purpose: Wire-level checks beside the link between host and device ends.
// Assumes: Host end built with a half period of 8 pclk cycles.
// Notes: Sees only the interface signals.
`timescale 1ns/1ns
module rtc_link_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic sclk,
  input wire logic host_sio_oe,
  input wire logic dev_sio_oe,
  input wire logic dev_irq_out,
  input wire logic dev_irq_oe,
  input wire logic subclk_out_pin,
  input wire logic subclk_control_pin
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_sub_pin_low: assert property (!subclk_control_pin [*6] |-> !subclk_out_pin)
    else $error("sub-clock output runs with control pin low");
  chk_irq_open_drain: assert property (dev_irq_oe |-> !dev_irq_out)
    else $error("interrupt pin driven high");
  chk_dev_release: assert property (!ce [*6] |-> !dev_sio_oe)
    else $error("device drives data line outside a frame");
  chk_sclk_idle: assert property (!ce |-> !sclk)
    else $error("serial clock high outside a frame");
  chk_sclk_high: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high half not 8 cycles");
  chk_ce_hold: assert property ($rose(ce) |-> ce [*8])
    else $error("chip enable dropped early");
  chk_host_drives: assert property ($rose(ce) |-> host_sio_oe && !sclk)
    else $error("host not driving at frame start");
  chk_sio_single: assert property (!(host_sio_oe && dev_sio_oe))
    else $error("both ends drive the data line");
endmodule : rtc_link_checker

/* tb/rtc_timekeeping_status_flags_test.sv */
// Purpose: Self-checking bench for both ends of the clock link.
// Assumes: Crystal divider of 2, so one second is 65536 pclk cycles.
// Notes: Device registers are reached over APB through the host end.
`timescale 1ns/1ns
`include "rtc_defs.svh"
module rtc_timekeeping_status_flags_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic osc_halt = 1'b0;
  logic w_match = 1'b0;
  logic d_match = 1'b0;
  logic [31:0] rd;
  logic [7:0] b;
  logic err;
  int failures = 0;
  int total_checks = 0;
  int i;
  int n;
  // Index, write value, read-back value
  logic [19:0] rows [8] = '{20'h0a525, 20'h1d959, 20'h2d212, 20'h3fd05,
    20'h4d515, 20'h5e989, 20'h64242, 20'h7ff7f};
  // Disable b, disable a, control pin, output expected
  logic [23:0] sub_rows [4] = '{24'h001011, 24'h100011, 24'h100810, 24'h000800};
  logic [7:0] roll_in [7] = '{8'h59, 8'h59, 8'h23, 8'h06, 8'h31, 8'h12, 8'h99};
  logic [7:0] roll_out [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h81, 8'h00};

  always #25 pclk = ~pclk;

  rtc_link_if link();
  rtc_dev #(.XTAL_DIV(2)) u_rtc_dev (.pclk(pclk), .presetn(presetn), .osc_halt(osc_halt),
    .weekly_alarm_match(w_match), .daily_alarm_match(d_match), .bus(link.dev));
  rtc_host #(.SCLK_HALF(8)) u_rtc_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(link.host));
  rtc_link_checker u_rtc_link_checker (.pclk(pclk), .presetn(presetn), .ce(link.ce),
    .sclk(link.sclk), .host_sio_oe(link.host_sio_oe), .dev_sio_oe(link.dev_sio_oe),
    .dev_irq_out(link.dev_irq_out), .dev_irq_oe(link.dev_irq_oe),
    .subclk_out_pin(link.subclk_out_pin), .subclk_control_pin(link.subclk_control_pin));

  task automatic final_report;
    $display("Checks made %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 50) begin
      failures++;
      final_report();
    end
  endtask : apb

  // One device register per frame; poll busy until the frame is done
  task automatic dev(input logic wr, input logic [3:0] idx, input logic [7:0] d);
    int k;
    apb(1'b1, `RTC_H_CMD, {8'h00, d, 7'h00, ~wr, 4'h0, idx});
    for (k = 0; k < 400; k++) begin
      apb(1'b0, `RTC_H_STAT, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (k == 400) begin
      failures++;
      final_report();
    end
    b = rd[15:8];
  endtask : dev

  task automatic rdc(input logic [3:0] idx, input logic [7:0] exp);
    dev(1'b0, idx, 8'h00);
    check({24'h0, b}, {24'h0, exp});
  endtask : rdc

  task automatic pin(input logic exp);
    check({31'h0, link.irq_out_pin}, {31'h0, exp});
  endtask : pin

  // Lets the pin settle, then counts sub-clock edges over 40 cycles
  task automatic sub_run(output int c);
    logic p;
    c = 0;
    cyc(4);
    p = link.subclk_out_pin;
    repeat (40) begin
      @(negedge pclk);
      if (link.subclk_out_pin !== p) c++;
      p = link.subclk_out_pin;
    end
  endtask : sub_run

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 8; i++) begin
      dev(1'b1, rows[i][19:16], rows[i][15:8]);
      rdc(rows[i][19:16], rows[i][7:0]);
    end
    apb(1'b0, 12'h0f0, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // Second reset in mid-run behaves as power-on
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    rdc(`RTC_A_CTRL2, `RTC_R_CTRL2);
    rdc(`RTC_A_CTRL1, 8'h00);
    rdc(`RTC_A_ADJ, 8'h00);
    rdc(`RTC_A_MDAY, 8'h01);
    dev(1'b1, `RTC_A_CTRL2, 8'h00);
    rdc(`RTC_A_CTRL2, 8'h00);
    dev(1'b1, `RTC_A_CTRL1, 8'h20);
    dev(1'b1, `RTC_A_CTRL2, 8'h10);
    rdc(`RTC_A_CTRL2, 8'h00);
    osc_halt <= 1'b1;
    cyc(10);
    rdc(`RTC_A_CTRL2, `RTC_R_CTRL2);
    rdc(`RTC_A_CTRL1, 8'h00);
    osc_halt <= 1'b0;
    cyc(10);
    rdc(`RTC_A_CTRL2, `RTC_R_CTRL2);
    for (i = 0; i < 4; i++) begin
      dev(1'b1, `RTC_A_CTRL1, sub_rows[i][23:16]);
      dev(1'b1, `RTC_A_CTRL2, sub_rows[i][15:8]);
      apb(1'b1, `RTC_H_CTRL, {31'h0, sub_rows[i][4]});
      sub_run(n);
      check({31'h0, n > 0}, {31'h0, sub_rows[i][0]});
      check({31'h0, link.subclk_out_pin & ~sub_rows[i][0]}, 32'h0);
    end
    dev(1'b1, `RTC_A_CTRL1, 8'h80);
    w_match <= 1'b1;
    cyc(1);
    w_match <= 1'b0;
    cyc(1200);
    pin(1'b1);
    cyc(40);
    pin(1'b0);
    rdc(`RTC_A_CTRL2, 8'h0a);
    apb(1'b0, `RTC_H_STAT, 32'h0);
    check({31'h0, rd[1]}, 32'h1);
    dev(1'b1, `RTC_A_CTRL2, 8'h0a);
    rdc(`RTC_A_CTRL2, 8'h0a);
    dev(1'b1, `RTC_A_CTRL2, 8'h08);
    rdc(`RTC_A_CTRL2, 8'h08);
    pin(1'b1);
    d_match <= 1'b1;
    cyc(1);
    d_match <= 1'b0;
    cyc(1300);
    rdc(`RTC_A_CTRL2, 8'h08);
    pin(1'b1);
    dev(1'b1, `RTC_A_CTRL1, 8'h40);
    rdc(`RTC_A_CTRL2, 8'h09);
    pin(1'b0);
    dev(1'b1, `RTC_A_CTRL2, 8'h08);
    dev(1'b1, `RTC_A_CTRL1, 8'h01);
    rdc(`RTC_A_CTRL2, 8'h0c);
    pin(1'b0);
    dev(1'b1, `RTC_A_CTRL1, 8'h00);
    rdc(`RTC_A_CTRL2, 8'h08);
    pin(1'b1);
    // Last second of the century, 24-hour mode, level periodic each second
    dev(1'b1, `RTC_A_CTRL1, 8'h24);
    for (i = 6; i >= 0; i--) begin
      dev(1'b1, i[3:0], roll_in[i]);
    end
    cyc(62800);
    rdc(`RTC_A_SEC, 8'h59);
    pin(1'b1);
    cyc(3000);
    for (i = 0; i < 7; i++) begin
      rdc(i[3:0], roll_out[i]);
    end
    pin(1'b0);
    rdc(`RTC_A_CTRL2, 8'h0c);
    dev(1'b1, `RTC_A_CTRL2, 8'h08);
    rdc(`RTC_A_CTRL2, 8'h08);
    pin(1'b1);
    final_report();
  end
endmodule : rtc_timekeeping_status_flags_test
